// ---- lkd_top.sv ----
// Purpose: AHB-Lite register bank of a frequency lock detector
// Assumes: Zero wait state slave, word transfers only
// Notes:   Error inputs come from another domain and are synchronised
//
// Functional notes
// RULE1: Low register holds error bits seven to zero
// RULE2: High register bits one, zero hold error top
// RULE3: High register bit three gives ppb/ppm unit
// RULE4: High register bit two shows lock state
// RULE5: High register bit four flags measurement done
// RULE6: Host writes zeros to reserved high bits
// RULE7: Detector runs only while run bit set
// RULE8: Three-bit limit selects threshold and interval
// RULE9: Control bit zero disables the detector
// RULE10: Error, unit and lock update together
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module lkd_top #(
    parameter logic [lkd_pkg::CW-1:0] INTV0_CYC = lkd_pkg::IVL0_CYC,
    parameter logic [lkd_pkg::CW-1:0] INTV1_CYC = lkd_pkg::IVL1_CYC,
    parameter logic [lkd_pkg::CW-1:0] INTV2_CYC = lkd_pkg::IVL2_CYC,
    parameter logic [lkd_pkg::CW-1:0] INTV3_CYC = lkd_pkg::IVL3_CYC,
    parameter logic [lkd_pkg::CW-1:0] INTV4_CYC = lkd_pkg::IVL4_CYC,
    parameter logic [lkd_pkg::CW-1:0] INTV5_CYC = lkd_pkg::IVL5_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [9:0] FERR_MAG,
    input wire logic FERR_PPM,
    output logic IRQ
);
    logic [9:0] mag_s1;
    logic [9:0] mag_s2;
    logic ppm_s1;
    logic ppm_s2;
    logic ctrl_run;
    logic ctrl_disable;
    logic [2:0] ctrl_limit;
    logic [lkd_pkg::IRQ_W-1:0] irq_stat;
    logic [lkd_pkg::IRQ_W-1:0] irq_mask;
    logic [lkd_pkg::IRQ_W-1:0] irq_ev;
    logic [lkd_pkg::IRQ_W-1:0] irq_clr;
    logic [lkd_pkg::IRQ_W-1:0] next_stat;
    logic locked_d;
    logic addr_take;
    logic addr_ok;
    logic wr_pend;
    logic [5:0] wr_idx;
    logic [31:0] next_rdata;

    lkd_meas_if mif ();

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mag_s1 <= '0;
            mag_s2 <= '0;
            ppm_s1 <= 1'b0;
            ppm_s2 <= 1'b0;
        end else begin
            mag_s1 <= FERR_MAG;
            mag_s2 <= mag_s1;
            ppm_s1 <= FERR_PPM;
            ppm_s2 <= ppm_s1;
        end
    end

    // ----------------------------------------------------------------
    // Measurement core
    // ----------------------------------------------------------------
    assign mif.run = ctrl_run && !ctrl_disable; // RULE7 RULE9
    assign mif.limit_sel = ctrl_limit; // RULE8
    assign mif.err_mag = mag_s2;
    assign mif.err_ppm = ppm_s2;

    lkd_meas #(
        .IVL_TAB({lkd_pkg::IVL7_CYC, lkd_pkg::IVL6_CYC, INTV5_CYC,
            INTV4_CYC, INTV3_CYC, INTV2_CYC, INTV1_CYC, INTV0_CYC})
    ) u_meas (
        .clk(CLK_SYS),
        .rst(RST),
        .m(mif.meas)
    );

    // ----------------------------------------------------------------
    // AHB-Lite address phase
    // ----------------------------------------------------------------
    assign addr_take = HSEL && HTRANS[1] && HREADY;
    assign addr_ok = (HADDR[31:8] == '0) && (HADDR[1:0] == '0);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wr_pend <= 1'b0;
            wr_idx <= '0;
        end else begin
            wr_pend <= addr_take && HWRITE && addr_ok;
            wr_idx <= HADDR[7:2];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data, latched at the end of the address phase
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (addr_ok) begin
            case (HADDR[7:2])
                lkd_pkg::IDX_CTRL: begin
                    next_rdata[lkd_pkg::CTRL_DIS_BIT] = ctrl_disable;
                    next_rdata[lkd_pkg::CTRL_LIM_LSB +: 3] = ctrl_limit;
                    next_rdata[lkd_pkg::CTRL_RUN_BIT] = ctrl_run;
                end
                lkd_pkg::IDX_ERR_LOW: begin
                    next_rdata[7:0] = mif.mag[7:0]; // RULE1
                end
                lkd_pkg::IDX_ERR_HIGH: begin
                    next_rdata[lkd_pkg::HI_MAG_LSB +: 2] = mif.mag[9:8]; // RULE2
                    next_rdata[lkd_pkg::HI_LOCK_BIT] = mif.locked; // RULE4
                    next_rdata[lkd_pkg::HI_UNIT_BIT] = mif.ppm; // RULE3
                    next_rdata[lkd_pkg::HI_DONE_BIT] = mif.done; // RULE5
                end
                lkd_pkg::IDX_IRQ_STAT: begin
                    next_rdata[lkd_pkg::IRQ_W-1:0] = irq_stat;
                end
                lkd_pkg::IDX_IRQ_MASK: begin
                    next_rdata[lkd_pkg::IRQ_W-1:0] = irq_mask;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            HRDATA <= '0;
        end else if (addr_take && !HWRITE) begin
            HRDATA <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Control register, live without update strobe
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_run <= 1'b0;
            ctrl_disable <= 1'b0;
            ctrl_limit <= lkd_pkg::LIM_DEF; // RULE8
        end else if (wr_pend && wr_idx == lkd_pkg::IDX_CTRL) begin
            ctrl_run <= HWDATA[lkd_pkg::CTRL_RUN_BIT]; // RULE7
            ctrl_disable <= HWDATA[lkd_pkg::CTRL_DIS_BIT]; // RULE9
            ctrl_limit <= HWDATA[lkd_pkg::CTRL_LIM_LSB +: 3]; // RULE8
        end
    end

    // ----------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ----------------------------------------------------------------
    always_comb begin
        irq_ev = '0;
        irq_ev[lkd_pkg::EV_DONE] = mif.done_pulse;
        irq_ev[lkd_pkg::EV_GAIN] = mif.locked && !locked_d;
        irq_ev[lkd_pkg::EV_LOSS] = !mif.locked && locked_d;
        irq_clr = '0;
        if (wr_pend && wr_idx == lkd_pkg::IDX_IRQ_STAT) begin
            irq_clr = HWDATA[lkd_pkg::IRQ_W-1:0];
        end
        next_stat = (irq_stat & ~irq_clr) | irq_ev;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            locked_d <= 1'b0;
            irq_stat <= '0;
            IRQ <= 1'b0;
        end else begin
            locked_d <= mif.locked;
            irq_stat <= next_stat;
            IRQ <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_mask <= lkd_pkg::IRQ_MASK_DEF;
        end else if (wr_pend && wr_idx == lkd_pkg::IDX_IRQ_MASK) begin
            irq_mask <= HWDATA[lkd_pkg::IRQ_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence rd_at(logic [5:0] idx);
        addr_take && !HWRITE && addr_ok && HADDR[7:2] == idx;
    endsequence

    err_low_a: assert property ( // RULE1
        @(posedge CLK_SYS) disable iff (RST)
        rd_at(lkd_pkg::IDX_ERR_LOW)
        |=> HRDATA == {24'h00_0000, $past(mif.mag[7:0])})
        else $error("Low error byte wrong");
    err_high_a: assert property ( // RULE2
        @(posedge CLK_SYS) disable iff (RST)
        rd_at(lkd_pkg::IDX_ERR_HIGH)
        |=> HRDATA[1:0] == $past(mif.mag[9:8]) && HRDATA[31:5] == '0)
        else $error("High error bits wrong");
    unit_bit_a: assert property ( // RULE3
        @(posedge CLK_SYS) disable iff (RST)
        rd_at(lkd_pkg::IDX_ERR_HIGH) ##1 1'b1
        |-> HRDATA[lkd_pkg::HI_UNIT_BIT] == $past(mif.ppm))
        else $error("Unit bit wrong");
    lock_bit_a: assert property ( // RULE4
        @(posedge CLK_SYS) disable iff (RST)
        rd_at(lkd_pkg::IDX_ERR_HIGH)
        |=> HRDATA[lkd_pkg::HI_LOCK_BIT] == $past(mif.locked))
        else $error("Lock bit wrong");
    done_bit_a: assert property ( // RULE5
        @(posedge CLK_SYS) disable iff (RST)
        rd_at(lkd_pkg::IDX_ERR_HIGH)
        |=> HRDATA[lkd_pkg::HI_DONE_BIT] == $past(mif.done))
        else $error("Done bit wrong");
    limit_default_a: assert property ( // RULE8
        @(posedge CLK_SYS) $fell(RST) |-> ctrl_limit == lkd_pkg::LIM_DEF)
        else $error("Limit default wrong");
    disable_gate_a: assert property ( // RULE9
        @(posedge CLK_SYS) disable iff (RST)
        ctrl_disable |=> !mif.done)
        else $error("Disabled detector reported done");
    irq_level_a: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        |(irq_stat & irq_mask) |=> IRQ)
        else $error("Interrupt not raised");

    irq_cov_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        $rose(IRQ));
    loss_cov_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        irq_ev[lkd_pkg::EV_LOSS]);
    read_cov_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        rd_at(lkd_pkg::IDX_ERR_HIGH));
endmodule

// ---- lkd_pkg.sv ----
// Purpose: Constants for the lock detector readback block
// Assumes: System clock of 10 MHz
// Notes:   Register indices map to byte address index * 4
package lkd_pkg;
    // ----------------------------------------------------------------
    // Register map (index, byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL = 6'h1d;
    localparam logic [5:0] IDX_ERR_LOW = 6'h1e;
    localparam logic [5:0] IDX_ERR_HIGH = 6'h1f;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_DIS_BIT = 0;
    localparam int CTRL_LIM_LSB = 1;
    localparam int CTRL_RUN_BIT = 4;
    localparam int HI_MAG_LSB = 0;
    localparam int HI_LOCK_BIT = 2;
    localparam int HI_UNIT_BIT = 3;
    localparam int HI_DONE_BIT = 4;
    localparam int IRQ_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_GAIN = 1;
    localparam int EV_LOSS = 2;
    // ----------------------------------------------------------------
    // Reset values, and the first limit that uses ppm
    // ----------------------------------------------------------------
    localparam logic [2:0] LIM_DEF = 3'h2;
    localparam logic [2:0] LIM_PPM_FIRST = 3'h4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_DEF = 3'h0;
    // ----------------------------------------------------------------
    // Timing: update intervals in microseconds
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int IVL0_US = 670_000;
    localparam int IVL1_US = 170_000;
    localparam int IVL2_US = 42_000;
    localparam int IVL3_US = 10_000;
    localparam int IVL4_US = 2_600;
    localparam int IVL5_US = 660;
    localparam int IVL6_US = 160;
    localparam int IVL7_US = 41;
    localparam int CW = 24;
    localparam logic [CW-1:0] IVL0_CYC = CW'(IVL0_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL1_CYC = CW'(IVL1_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL2_CYC = CW'(IVL2_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL3_CYC = CW'(IVL3_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL4_CYC = CW'(IVL4_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL5_CYC = CW'(IVL5_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL6_CYC = CW'(IVL6_US * CLK_MHZ);
    localparam logic [CW-1:0] IVL7_CYC = CW'(IVL7_US * CLK_MHZ);
    // ----------------------------------------------------------------
    // Thresholds in tenths of a unit, entry 0 in the low bits
    // ----------------------------------------------------------------
    localparam int TW = 14;
    localparam logic [8*TW-1:0] LIM_TAB = {
        14'h0988, 14'h0262, 14'h0096, 14'h0026,
        14'h2544, 14'h094c, 14'h0258, 14'h0096};
endpackage

// ---- lkd_meas_if.sv ----
// Purpose: Carrier between register front end and measurement core
// Assumes: One clock domain
// Notes:   Results change only at the end of an interval
`timescale 1ns/100ps
interface lkd_meas_if;
    logic run;
    logic [2:0] limit_sel;
    logic [9:0] err_mag;
    logic err_ppm;
    logic [9:0] mag;
    logic ppm;
    logic locked;
    logic done;
    logic done_pulse;
    modport meas (input run, limit_sel, err_mag, err_ppm,
        output mag, ppm, locked, done, done_pulse);
    modport ctl (output run, limit_sel, err_mag, err_ppm,
        input mag, ppm, locked, done, done_pulse);
endinterface

// ---- lkd_meas.sv ----
// Purpose: Interval timer and result capture of the lock detector
// Assumes: Error inputs already synchronised
// Notes:   Interval table passed in packed, entry 0 lowest
`timescale 1ns/100ps
module lkd_meas #(
    parameter logic [8*lkd_pkg::CW-1:0] IVL_TAB = '1
) (
    input wire logic clk,
    input wire logic rst,
    lkd_meas_if.meas m
);
    logic [lkd_pkg::CW-1:0] cnt;
    logic [lkd_pkg::CW-1:0] ivl;
    logic [lkd_pkg::TW-1:0] thr;
    logic [lkd_pkg::TW-1:0] mag10;
    logic thr_ppm;
    logic fin;
    logic next_locked;

    // ----------------------------------------------------------------
    // Interval and threshold selection
    // ----------------------------------------------------------------
    assign ivl = IVL_TAB[m.limit_sel*lkd_pkg::CW +: lkd_pkg::CW];
    assign thr = lkd_pkg::LIM_TAB[m.limit_sel*lkd_pkg::TW +: lkd_pkg::TW];
    assign thr_ppm = (m.limit_sel >= lkd_pkg::LIM_PPM_FIRST); // RULE8
    assign mag10 = ({4'h0, m.err_mag} << 3) + ({4'h0, m.err_mag} << 1);
    assign fin = m.run && (cnt >= ivl - 1'b1); // RULE8

    always_comb begin
        if (m.err_ppm == thr_ppm) begin
            next_locked = (mag10 <= thr);
        end else begin
            next_locked = !m.err_ppm;
        end
    end

    // ----------------------------------------------------------------
    // Interval counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || !m.run || fin) begin // RULE7
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Result capture, all fields in one step
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            m.mag <= '0;
            m.ppm <= 1'b0;
            m.locked <= 1'b0;
        end else if (fin) begin // RULE10
            m.mag <= m.err_mag;
            m.ppm <= m.err_ppm;
            m.locked <= next_locked;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !m.run) begin // RULE7
            m.done <= 1'b0;
            m.done_pulse <= 1'b0;
        end else begin
            m.done_pulse <= fin;
            if (fin) begin // RULE5
                m.done <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    joint_update_a: assert property (@(posedge clk) disable iff (rst) // RULE10
        ($changed(m.mag) || $changed(m.ppm) || $changed(m.locked))
        |-> $past(fin))
        else $error("Result changed outside interval end");
    run_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE7
        !m.run |=> !m.done && !m.done_pulse)
        else $error("Detector active while stopped");
    done_cov_c: cover property (@(posedge clk) disable iff (rst)
        m.done_pulse && m.locked);
endmodule

// ---- lkd_top_tb_top.sv ----
// Purpose: Self-checking bench for the lock detector register bank
// Assumes: Zero wait state AHB-Lite slave, one clock, intervals 0 to 4 shortened
// Notes:   Driver queues expected read data, monitor compares it
`timescale 1ns/100ps
module lkd_top_tb_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int CYC_LIMIT = 40000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [9:0] ferr_mag = 10'h000;
    logic ferr_ppm = 1'b0;
    logic rd_ph = 1'b0;
    logic prev_lock = 1'b0;
    logic [31:0] last_lo;
    logic [31:0] last_hi;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    logic [31:0] exp_q[$];
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int thr_tab[8] = '{150, 600, 2380, 9540, 38, 150, 610, 2440};
    int ivl_tab[8] = '{200, 170, 150, 120, 100, 6600, 1600, 410};

    lkd_top #(.INTV0_CYC(24'h00_00c8), .INTV1_CYC(24'h00_00aa),
        .INTV2_CYC(24'h00_0096), .INTV3_CYC(24'h00_0078),
        .INTV4_CYC(24'h00_0064)) u_lkd_top (
        .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .FERR_MAG(ferr_mag),
        .FERR_PPM(ferr_ppm), .IRQ(irq));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] e);
        n_tests++;
        if (hrdata !== e || hresp !== 1'b0) begin
            err_total++;
            $display("MISMATCH at %0t: read %h expected %h", $time,
                hrdata, e);
        end
    endtask

    task automatic chk_irq(input logic e);
        n_tests++;
        if (irq !== e) begin
            err_total++;
            $display("MISMATCH at %0t: irq %b expected %b", $time, irq, e);
        end
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            err_total++;
            $display("MISMATCH at %0t: run timed out", $time);
            end_of_test;
        end
    end

    always @(posedge clk_sys) begin
        if (rd_ph && hreadyout === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("MISMATCH at %0t: read with no note", $time);
            end else begin
                chk_word(exp_q.pop_front());
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus driver
    // ----------------------------------------------------------------
    task automatic wait_ready;
        do begin
            @(posedge clk_sys);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [5:0] idx,
        input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= w ? wd : 32'h0000_0000;
        rd_ph <= !w;
        wait_ready;
        rd_ph <= 1'b0;
        hsel <= 1'b0;
        // Idle edge so the next call never reassigns in this time step
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h0000_0000);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    // ----------------------------------------------------------------
    // One measurement; quiet runs it with the done interrupt masked
    // ----------------------------------------------------------------
    task automatic meas(input int lim, input logic [9:0] mag,
        input logic ppm, input logic quiet);
        logic lk;
        logic [2:0] st;
        if (ppm == (lim >= 4)) begin
            lk = (int'(mag) * 10 <= thr_tab[lim]);
        end else begin
            lk = !ppm;
        end
        st = {prev_lock & !lk, !prev_lock & lk, 1'b1};
        prev_lock = lk;
        last_lo = {24'h00_0000, mag[7:0]};
        last_hi = {24'h00_0000, 3'b000, 1'b1, ppm, lk, mag[9:8]};
        ferr_mag <= mag;
        ferr_ppm <= ppm;
        wr(lkd_pkg::IDX_IRQ_MASK, quiet ? 32'h0000_0000 : 32'h0000_0001);
        wr(lkd_pkg::IDX_CTRL, {27'h000_0000, 1'b1, 3'(lim), 1'b0});
        if (quiet) begin
            repeat (ivl_tab[lim] + 20) @(posedge clk_sys);
            chk_irq(1'b0);
        end else begin
            while (irq !== 1'b1) @(posedge clk_sys);
        end
        rd(lkd_pkg::IDX_ERR_LOW, last_lo);
        rd(lkd_pkg::IDX_ERR_HIGH, last_hi);
        rd(lkd_pkg::IDX_IRQ_STAT, {29'h0000_0000, st});
        if (quiet) begin
            wr(lkd_pkg::IDX_IRQ_MASK, 32'h0000_0001);
            repeat (2) @(posedge clk_sys);
            chk_irq(1'b1);
        end
        wr(lkd_pkg::IDX_IRQ_STAT, 32'h0000_0007);
        wr(lkd_pkg::IDX_CTRL, 32'h0000_0000);
        chk_irq(1'b0);
        last_hi[4] = 1'b0;
        $display("test measurement limit %0d done", lim);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] ctl;
        void'($urandom(49));
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(lkd_pkg::IDX_CTRL, 32'h0000_0004);
        rd(lkd_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        rd(6'h20, 32'h0000_0000);
        $display("test reset values done");
        wr(lkd_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        for (int j = 0; j < 2; j++) begin
            ctl = (j == 0) ? 32'h0000_001f : 32'h0000_000e;
            wr(lkd_pkg::IDX_CTRL, ctl);
            rd(lkd_pkg::IDX_CTRL, ctl);
            repeat (450) @(posedge clk_sys);
            chk_irq(1'b0);
            rd(lkd_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        end
        wr(lkd_pkg::IDX_CTRL, 32'h0000_0000);
        $display("test detector halted done");
        for (int i = 0; i < 8; i++) begin
            meas(i, 10'(thr_tab[i] / 10), i >= 4, 1'b0);
            meas(i, 10'($urandom % 1024), 1'($urandom % 2), i == 7);
        end
        wr(lkd_pkg::IDX_ERR_LOW, 32'h0000_00ff);
        wr(lkd_pkg::IDX_ERR_HIGH, 32'h0000_001f);
        rd(lkd_pkg::IDX_ERR_LOW, last_lo);
        rd(lkd_pkg::IDX_ERR_HIGH, last_hi);
        $display("test read-only registers done");
        @(posedge clk_sys);
        if (exp_q.size() != 0) begin
            err_total++;
            $display("MISMATCH at %0t: reads left unchecked", $time);
        end
        end_of_test;
    end
endmodule
